// *** gdps_pkg.sv ***
// constants, types and decode helpers for the gate drive protection sequencer
// assumes a single 200 MHz clock; all inputs already synchronous to it
// Notes on behaviour
// (R1) dead time 50 to 500 ns, set externally
// (R2) dead time is a minimum gap only
// (R3) gate turns on promptly after opposite confirmed off
// (R4) ready 5 ms typical after gate enable rises
// (R5) short enable low pulse clears faults only
// (R6) error drives all six gates low quickly
// (R7) error asserts active-low fault output quickly
// (R8) warning sets at 130, shutdown clears there
// (R9) warning clears at 115 for hysteresis
// (R10) shutdown at 150 or above
// (R11) serial port ready only after start-up delay
// (R12) serial port is slave only
// (R13) faults shown on both pins and status; undervoltage reaches only the fault pin and status
// (R14) overcurrent recorded per transistor
// (R15) overcurrent, overtemperature, undervoltage are faults
// (R16) high and low gate never on together
// (R17) overcurrent warning pulse stretched to 64 us
// (R18) six or three input pwm mode
// (R19) gates stay low until fault cleared
package gdps_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int DT_MIN_NS = 50;
  localparam int DT_MAX_NS = 500;
  localparam int HS_MAX_NS = 50;
  localparam int STARTUP_TYP_MS = 5;
  localparam int STARTUP_MAX_MS = 10;
  localparam int QUICK_MAX_US = 10;
  localparam int ERR_RESP_NS = 200;
  localparam int OC_STRETCH_US = 64;

  localparam int DT_MIN_CYC = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_MAX_CYC = DT_MAX_NS / CLK_PERIOD_NS;
  localparam int HS_MAX_CYC = HS_MAX_NS / CLK_PERIOD_NS;
  localparam int STARTUP_TYP_CYC = STARTUP_TYP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STARTUP_MAX_CYC = STARTUP_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int QUICK_MAX_CYC = QUICK_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int ERR_RESP_CYC = ERR_RESP_NS / CLK_PERIOD_NS;
  localparam int OC_STRETCH_CYC = OC_STRETCH_US * 1000 / CLK_PERIOD_NS;

  localparam int DT_W = 7;
  localparam int CNT_W = 21;
  localparam int STR_W = 14;
  localparam int TEMP_W = 8;
  localparam int PHASES = 3;

  localparam logic [TEMP_W-1:0] OTW_SET_C = 8'h82;
  localparam logic [TEMP_W-1:0] OTW_CLR_C = 8'h73;
  localparam logic [TEMP_W-1:0] OVERTEMP_SHUTDOWN_SET_C = 8'h96;
  localparam logic [TEMP_W-1:0] OVERTEMP_SHUTDOWN_CLR_C = 8'h82;

  localparam logic [CNT_W-1:0] CNT_RST = 21'h0_0000;
  localparam logic [STR_W-1:0] STR_RST = 14'h0000;
  localparam logic [DT_W-1:0] DT_RST = 7'h00;

  typedef enum logic [2:0] {
    GDPS_OFF,
    GDPS_STARTUP,
    GDPS_READY,
    GDPS_FAULT,
    GDPS_QUICK
  } gdps_state_t;

  // returns {want_high, want_low} for one phase
  function automatic logic [1:0] gdps_decode(input logic three_mode, input logic hi, input logic lo);
    if (three_mode) begin
      gdps_decode = {hi, ~hi};
    end else begin
      gdps_decode = {hi & ~lo, lo & ~hi};
    end
  endfunction

  function automatic logic [DT_W-1:0] gdps_clamp_dt(input logic [DT_W-1:0] code);
    if (code < DT_W'(DT_MIN_CYC)) begin
      gdps_clamp_dt = DT_W'(DT_MIN_CYC);
    end else if (code > DT_W'(DT_MAX_CYC)) begin
      gdps_clamp_dt = DT_W'(DT_MAX_CYC);
    end else begin
      gdps_clamp_dt = code;
    end
  endfunction
endpackage

// *** gdps_phase_if.sv ***
// per-phase carrier between the sequencer and one half-bridge
// assumes the sequencer drives requests and the bridge returns gate levels
`timescale 1ns/10ps
`default_nettype none
interface gdps_phase_if;
  import gdps_pkg::*;
  logic pwm_h;
  logic pwm_l;
  logic three_mode;
  logic gate_en;
  logic [DT_W-1:0] dead_cyc;
  logic gate_h;
  logic gate_l;
  modport ctrl (output pwm_h, output pwm_l, output three_mode, output gate_en, output dead_cyc,
                input gate_h, input gate_l);
  modport bridge (input pwm_h, input pwm_l, input three_mode, input gate_en, input dead_cyc,
                  output gate_h, output gate_l);
endinterface
`default_nettype wire

// *** gdps_half_bridge.sv ***
// one half-bridge: pwm decode, handshake and minimum dead time
// assumes gate_en drops in the cycle an error is seen
`timescale 1ns/10ps
`default_nettype none
module gdps_half_bridge (
  input wire logic i_clk,
  input wire logic i_arst_n,
  gdps_phase_if.bridge ph
);
  import gdps_pkg::*;

  logic gh_r, gh_nxt;
  logic gl_r, gl_nxt;
  logic [DT_W-1:0] gap_r, gap_nxt;
  logic [1:0] want;
  logic gap_done;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    want = gdps_decode(ph.three_mode, ph.pwm_h, ph.pwm_l); // R18
    // gap counts cycles with both gates low; a long controller gap already fills it
    gap_done = (gap_r >= ph.dead_cyc - 7'h01); // R1 R2
    gh_nxt = gh_r & want[1];
    gl_nxt = gl_r & want[0];
    if (!ph.gate_en) begin
      gh_nxt = 1'b0; // R6 R19
      gl_nxt = 1'b0; // R6 R19
    end else if (gap_done && !gh_r && !gl_r) begin
      // handshake: turn on only once the opposite output is seen low
      gh_nxt = want[1]; // R3 R16
      gl_nxt = want[0] & ~want[1]; // R3 R16
    end
    if (gh_r || gl_r) begin
      gap_nxt = DT_RST;
    end else if (gap_r < DT_W'(DT_MAX_CYC)) begin
      gap_nxt = gap_r + 7'h01;
    end else begin
      gap_nxt = gap_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gh_r <= 1'b0;
      gl_r <= 1'b0;
      gap_r <= DT_RST;
    end else begin
      gh_r <= gh_nxt;
      gl_r <= gl_nxt;
      gap_r <= gap_nxt;
    end
  end

  assign ph.gate_h = gh_r;
  assign ph.gate_l = gl_r;
endmodule
`default_nettype wire

// *** gdps_temp_monitor.sv ***
// junction temperature comparators with hysteresis
// assumes a temperature reading in whole degrees, synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module gdps_temp_monitor (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [gdps_pkg::TEMP_W-1:0] i_temp_c,
  output logic o_overtemp_warning,
  output logic o_overtemp_shutdown
);
  import gdps_pkg::*;

  logic otw_r, otw_nxt;
  logic overtemp_shutdown_r, overtemp_shutdown_nxt;

  always_comb begin
    otw_nxt = otw_r;
    overtemp_shutdown_nxt = overtemp_shutdown_r;
    if (i_temp_c >= OTW_SET_C) begin
      otw_nxt = 1'b1; // R8
    end else if (i_temp_c <= OTW_CLR_C) begin
      otw_nxt = 1'b0; // R9
    end
    if (i_temp_c >= OVERTEMP_SHUTDOWN_SET_C) begin
      overtemp_shutdown_nxt = 1'b1; // R10
    end else if (i_temp_c <= OVERTEMP_SHUTDOWN_CLR_C) begin
      overtemp_shutdown_nxt = 1'b0; // R8
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      otw_r <= 1'b0;
      overtemp_shutdown_r <= 1'b0;
    end else begin
      otw_r <= otw_nxt;
      overtemp_shutdown_r <= overtemp_shutdown_nxt;
    end
  end

  assign o_overtemp_warning = otw_r;
  assign o_overtemp_shutdown = overtemp_shutdown_r;
endmodule
`default_nettype wire

// *** gdps_top.sv ***
// gate drive protection sequencer: enable sequencing, fault latch, reporting
// assumes pwm, sense and temperature inputs are synchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module gdps_top #(
  parameter logic [gdps_pkg::CNT_W-1:0] P_STARTUP_CYC = gdps_pkg::CNT_W'(gdps_pkg::STARTUP_TYP_CYC),
  parameter logic [gdps_pkg::STR_W-1:0] P_OC_STRETCH_CYC = gdps_pkg::STR_W'(gdps_pkg::OC_STRETCH_CYC)
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_en_gate,
  input wire logic i_supply_ok,
  input wire logic i_undervoltage,
  input wire logic [gdps_pkg::PHASES-1:0] i_high_side_pwm_in,
  input wire logic [gdps_pkg::PHASES-1:0] i_low_side_pwm_in,
  input wire logic i_pwm_three_input_mode,
  input wire logic [gdps_pkg::DT_W-1:0] i_dead_time_resistor_pin_code,
  input wire logic [2*gdps_pkg::PHASES-1:0] i_vds_overcurrent,
  input wire logic [gdps_pkg::TEMP_W-1:0] i_junction_temp_c,
  input wire logic i_fault_clear,
  input wire logic i_spi_cs_n,
  output logic [gdps_pkg::PHASES-1:0] o_high_side_gate_out,
  output logic [gdps_pkg::PHASES-1:0] o_low_side_gate_out,
  output logic o_fault_out_n,
  output logic o_overcurrent_temp_warn_out_n,
  output logic o_spi_ready,
  output logic o_spi_select_ok,
  output logic [2*gdps_pkg::PHASES-1:0] o_oc_status,
  output logic o_uv_status,
  output logic o_overtemp_shutdown_status,
  output logic o_overtemp_warning,
  output logic o_gate_ready
);
  import gdps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and status

  gdps_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [STR_W-1:0] str_r, str_nxt;
  logic [2*PHASES-1:0] oc_prev_r, oc_prev_nxt;
  logic [2*PHASES-1:0] oc_stat_r, oc_stat_nxt;
  logic uv_stat_r, uv_stat_nxt;
  logic overtemp_shutdown_stat_r, overtemp_shutdown_stat_nxt;
  logic fault_n_r, fault_n_nxt;
  logic warn_n_r, warn_n_nxt;
  logic spi_rdy_r, spi_rdy_nxt;

  logic overtemp_warning;
  logic overtemp_shutdown;
  logic err;
  logic clear_evt;
  logic oc_event;
  logic gate_en;
  logic [DT_W-1:0] dead_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // temperature

  gdps_temp_monitor u_temp (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_temp_c(i_junction_temp_c),
    .o_overtemp_warning(overtemp_warning),
    .o_overtemp_shutdown(overtemp_shutdown)
  );

  ////////////////////////////////////////////////////////////////////////////
  // half-bridges

  gdps_phase_if ph_if [PHASES] ();

  assign dead_cyc = gdps_clamp_dt(i_dead_time_resistor_pin_code); // R1

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      assign ph_if[g].pwm_h = i_high_side_pwm_in[g];
      assign ph_if[g].pwm_l = i_low_side_pwm_in[g];
      assign ph_if[g].three_mode = i_pwm_three_input_mode; // R18
      assign ph_if[g].gate_en = gate_en;
      assign ph_if[g].dead_cyc = dead_cyc;
      assign o_high_side_gate_out[g] = ph_if[g].gate_h;
      assign o_low_side_gate_out[g] = ph_if[g].gate_l;

      gdps_half_bridge u_bridge (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .ph(ph_if[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // error detection and gate enable

  // every protection source counts as an error event
  assign err = (|i_vds_overcurrent) | i_undervoltage | overtemp_shutdown; // R15

  // combinational so the bridges drop their gates at the very next edge
  assign gate_en = (state_r == GDPS_READY) && !err; // R6

  assign oc_event = |(i_vds_overcurrent & ~oc_prev_r);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    clear_evt = 1'b0;
    case (state_r)
      GDPS_OFF: begin
        cnt_nxt = CNT_RST;
        if (i_en_gate && i_supply_ok) begin
          state_nxt = GDPS_STARTUP;
        end
      end
      GDPS_STARTUP: begin
        if (!i_en_gate || !i_supply_ok) begin
          state_nxt = GDPS_OFF;
        end else if (cnt_r >= P_STARTUP_CYC - 21'h0_0001) begin
          state_nxt = GDPS_READY; // R4 R11
        end else begin
          cnt_nxt = cnt_r + 21'h0_0001;
        end
      end
      GDPS_READY: begin
        if (!i_supply_ok) begin
          state_nxt = GDPS_OFF;
        end else if (!i_en_gate) begin
          state_nxt = GDPS_QUICK;
          cnt_nxt = 21'h0_0001;
        end else if (err) begin
          state_nxt = GDPS_FAULT; // R19
        end else if (i_fault_clear) begin
          clear_evt = 1'b1;
        end
      end
      GDPS_FAULT: begin
        if (!i_supply_ok) begin
          state_nxt = GDPS_OFF;
        end else if (!i_en_gate) begin
          state_nxt = GDPS_QUICK;
          cnt_nxt = 21'h0_0001;
        end else if (i_fault_clear) begin
          clear_evt = 1'b1;
          // a clear while the cause persists leaves the gates low
          if (!err) begin
            state_nxt = GDPS_READY; // R19
          end
        end
      end
      GDPS_QUICK: begin
        if (!i_supply_ok) begin
          state_nxt = GDPS_OFF;
        end else if (i_en_gate) begin
          // short low pulse: faults and driver reset, regulators stay up
          clear_evt = 1'b1; // R5
          state_nxt = GDPS_READY; // R5
        end else if (cnt_r >= CNT_W'(QUICK_MAX_CYC)) begin
          state_nxt = GDPS_OFF; // R5
        end else begin
          cnt_nxt = cnt_r + 21'h0_0001;
        end
      end
      default: begin
        state_nxt = GDPS_OFF;
        cnt_nxt = CNT_RST;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, pins and warning stretch

  always_comb begin
    oc_prev_nxt = i_vds_overcurrent;
    // new events win over a clear in the same cycle
    oc_stat_nxt = (clear_evt ? '0 : oc_stat_r) | i_vds_overcurrent; // R14
    uv_stat_nxt = (clear_evt ? 1'b0 : uv_stat_r) | i_undervoltage; // R13
    overtemp_shutdown_stat_nxt = (clear_evt ? 1'b0 : overtemp_shutdown_stat_r) | overtemp_shutdown; // R13
    if (oc_event) begin
      str_nxt = P_OC_STRETCH_CYC; // R17
    end else if (str_r != STR_RST) begin
      str_nxt = str_r - 14'h0001;
    end else begin
      str_nxt = str_r;
    end
    // fault pin follows the latched fault state and any live error
    fault_n_nxt = !(err || (state_nxt == GDPS_FAULT)); // R7 R13
    warn_n_nxt = !(overtemp_warning || oc_event || (str_r > 14'h0001)); // R13 R17
    spi_rdy_nxt = (state_nxt == GDPS_READY) || (state_nxt == GDPS_FAULT) || (state_nxt == GDPS_QUICK); // R11
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= GDPS_OFF;
      cnt_r <= CNT_RST;
      str_r <= STR_RST;
      oc_prev_r <= '0;
      oc_stat_r <= '0;
      uv_stat_r <= 1'b0;
      overtemp_shutdown_stat_r <= 1'b0;
      fault_n_r <= 1'b1;
      warn_n_r <= 1'b1;
      spi_rdy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      str_r <= str_nxt;
      oc_prev_r <= oc_prev_nxt;
      oc_stat_r <= oc_stat_nxt;
      uv_stat_r <= uv_stat_nxt;
      overtemp_shutdown_stat_r <= overtemp_shutdown_stat_nxt;
      fault_n_r <= fault_n_nxt;
      warn_n_r <= warn_n_nxt;
      spi_rdy_r <= spi_rdy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_fault_out_n = fault_n_r;
  assign o_overcurrent_temp_warn_out_n = warn_n_r;
  assign o_spi_ready = spi_rdy_r;
  // the controller owns clock and select; this end only qualifies a select
  assign o_spi_select_ok = spi_rdy_r & ~i_spi_cs_n; // R12
  assign o_oc_status = oc_stat_r;
  assign o_uv_status = uv_stat_r;
  assign o_overtemp_shutdown_status = overtemp_shutdown_stat_r;
  assign o_overtemp_warning = overtemp_warning;
  assign o_gate_ready = (state_r == GDPS_READY);
endmodule
`default_nettype wire

// *** gdps_top_monitor.sv ***
// assertion monitor for gdps_top, bound to every instance of it
// assumes it sees only top-level ports; one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module gdps_top_monitor #(
  parameter logic [13:0] P_OC_STRETCH_CYC = 14'h0014
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_en_gate,
  input wire logic i_undervoltage,
  input wire logic [5:0] i_vds_overcurrent,
  input wire logic [7:0] i_junction_temp_c,
  input wire logic i_spi_cs_n,
  input wire logic [2:0] o_high_side_gate_out,
  input wire logic [2:0] o_low_side_gate_out,
  input wire logic o_fault_out_n,
  input wire logic o_overcurrent_temp_warn_out_n,
  input wire logic o_spi_ready,
  input wire logic o_spi_select_ok,
  input wire logic [5:0] o_oc_status,
  input wire logic o_overtemp_shutdown_status,
  input wire logic o_overtemp_warning,
  input wire logic o_gate_ready
);
  import gdps_pkg::*;
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_cnt_nxt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////
  // low samples of the warning pin; saturates so a long warning cannot wrap
  always_comb begin
    lo_cnt_nxt = lo_cnt_r;
    if (o_overcurrent_temp_warn_out_n) begin
      lo_cnt_nxt = 16'h0000;
    end else if (lo_cnt_r != 16'hffff) begin
      lo_cnt_nxt = lo_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_cnt_r <= 16'h0000;
    end else begin
      lo_cnt_r <= lo_cnt_nxt;
    end
  end
  ////////////////////////////////////////
  sequence err_live;
    ((i_vds_overcurrent != 6'h00) || i_undervoltage) && o_gate_ready;
  endsequence
  sequence gates_low;
    (o_high_side_gate_out == 3'h0) && (o_low_side_gate_out == 3'h0);
  endsequence
  no_shoot_a: assert property ((o_high_side_gate_out & o_low_side_gate_out) == 3'h0)
    else $error("high and low gate on together");
  err_gates_a: assert property (err_live |=> gates_low)
    else $error("gates not low after error");
  err_fault_a: assert property (err_live |=> !o_fault_out_n)
    else $error("fault pin not low after error");
  oc_record_a: assert property ((i_vds_overcurrent != 6'h00) && o_gate_ready |=>
    (o_oc_status & $past(i_vds_overcurrent)) == $past(i_vds_overcurrent))
    else $error("overcurrent not recorded per transistor");
  // a release that follows the temperature warning is not an overcurrent pulse
  warn_stretch_a: assert property ($rose(o_overcurrent_temp_warn_out_n) && !$past(o_overtemp_warning, 2) |->
    lo_cnt_r >= 16'(P_OC_STRETCH_CYC))
    else $error("warning pulse too short");
  otw_set_a: assert property (i_junction_temp_c >= OTW_SET_C |=> o_overtemp_warning)
    else $error("warning not set");
  otw_clear_a: assert property (i_junction_temp_c <= OTW_CLR_C |=> !o_overtemp_warning)
    else $error("warning not cleared");
  // comparator flop, then the sticky status flop
  overtemp_shutdown_set_a: assert property (i_junction_temp_c >= OVERTEMP_SHUTDOWN_SET_C |-> ##2 o_overtemp_shutdown_status)
    else $error("shutdown not recorded");
  select_ok_a: assert property (o_spi_select_ok == (o_spi_ready && !i_spi_cs_n))
    else $error("select qualified wrongly");
  fault_hold_a: assert property (!o_fault_out_n |-> gates_low)
    else $error("gate on during fault");
  en_drop_a: assert property (!i_en_gate |=> !o_gate_ready)
    else $error("ready while enable low");
endmodule
bind gdps_top gdps_top_monitor #(.P_OC_STRETCH_CYC(P_OC_STRETCH_CYC)) gdps_top_monitor_inst (
  .i_clk, .i_arst_n, .i_en_gate, .i_undervoltage, .i_vds_overcurrent, .i_junction_temp_c, .i_spi_cs_n,
  .o_high_side_gate_out, .o_low_side_gate_out, .o_fault_out_n, .o_overcurrent_temp_warn_out_n,
  .o_spi_ready, .o_spi_select_ok, .o_oc_status, .o_overtemp_shutdown_status, .o_overtemp_warning, .o_gate_ready);
`default_nettype wire

// *** gdps_mcu_model.sv ***
// controller stand-in: pwm levels and serial select toward the gate driver
// assumes bench commands; pins move only on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module gdps_mcu_model (
  input wire logic i_clk,
  input wire logic [2:0] i_cmd_h,
  input wire logic [2:0] i_cmd_l,
  input wire logic i_want_spi,
  input wire logic i_spi_ready,
  output logic [2:0] o_pwm_h,
  output logic [2:0] o_pwm_l,
  output logic o_spi_cs_n
);
  initial begin
    o_pwm_h = 3'h0;
    o_pwm_l = 3'h0;
    o_spi_cs_n = 1'b1;
  end
  always @(negedge i_clk) begin
    o_pwm_h <= i_cmd_h;
    o_pwm_l <= i_cmd_l;
    // we are master of select, held off until the port says ready
    o_spi_cs_n <= ~(i_want_spi & i_spi_ready);
  end
endmodule
`default_nettype wire

// *** gdps_top_tb_top.sv ***
// bench for gdps_top: table model, controller stand-in, timeout
// assumes package, design, monitor and controller model compiled first
`timescale 1ns/10ps
`default_nettype none
module gdps_top_tb_top;
  import gdps_pkg::*;
  localparam int P_ST = 50;
  localparam int P_OC = 20;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic en = 1'b0;
  logic uv = 1'b0;
  logic three = 1'b0;
  logic clr = 1'b0;
  logic want = 1'b0;
  logic sup = 1'b1;
  logic cs_n;
  logic [2:0] ch = 3'h0;
  logic [2:0] cl = 3'h0;
  logic [2:0] ph, pl, gh, gl;
  logic [6:0] dt = 7'h0a;
  logic [5:0] vds = 6'h00;
  logic [7:0] temp = 8'h19;
  logic [5:0] ocs;
  logic fn, wn, rdy, sok, uvs, overtemp_shutdown, overtemp_warning, grdy;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int k, d, b, otw_m;
  int tq[$] = '{130, 116, 115, 150, 129};
  always #2.5 i_clk = ~i_clk;
  gdps_top #(.P_STARTUP_CYC(21'(P_ST)), .P_OC_STRETCH_CYC(14'(P_OC))) gdps_top_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_en_gate(en), .i_supply_ok(sup), .i_undervoltage(uv),
    .i_high_side_pwm_in(ph), .i_low_side_pwm_in(pl), .i_pwm_three_input_mode(three),
    .i_dead_time_resistor_pin_code(dt), .i_vds_overcurrent(vds), .i_junction_temp_c(temp),
    .i_fault_clear(clr), .i_spi_cs_n(cs_n), .o_high_side_gate_out(gh), .o_low_side_gate_out(gl),
    .o_fault_out_n(fn), .o_overcurrent_temp_warn_out_n(wn), .o_spi_ready(rdy), .o_spi_select_ok(sok),
    .o_oc_status(ocs), .o_uv_status(uvs), .o_overtemp_shutdown_status(overtemp_shutdown), .o_overtemp_warning(overtemp_warning),
    .o_gate_ready(grdy));
  gdps_mcu_model gdps_mcu_model_inst (
    .i_clk(i_clk), .i_cmd_h(ch), .i_cmd_l(cl), .i_want_spi(want), .i_spi_ready(rdy),
    .o_pwm_h(ph), .o_pwm_l(pl), .o_spi_cs_n(cs_n));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic fe();
    @(negedge i_clk);
  endtask
  // {high, low} per phase from the mode tables
  function automatic logic [1:0] gexp(input logic t, input logic h, input logic l);
    if (t) return {h, !h};
    return {h && !l, l && !h};
  endfunction
  // swap gates; gap from one falling to the other rising, in cycles
  task automatic gap(input logic to_h, input int dx);
    fe();
    ch <= {3{to_h}};
    cl <= {3{!to_h}};
    k = 0;
    while ((to_h ? gl : gh) !== 3'h0 && k < 9) begin
      cyc(1);
      k++;
    end
    k = 0;
    while ((to_h ? gh[0] : gl[0]) !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(k, dx);
    cyc(110);
  endtask
  task automatic fclear();
    fe();
    clr <= 1'b1;
    fe();
    clr <= 1'b0;
    cyc(1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ceiling well above the roughly 3k to 5k cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h3964));
    repeat (10) @(posedge i_clk);
    fe();
    i_arst_n <= 1'b1;
    cyc(1);
    chk({gh, gl, fn, wn, rdy, ocs, uvs, overtemp_shutdown, overtemp_warning, grdy}, {6'h00, 3'b110, 6'h00, 4'h0});
    fe();
    en <= 1'b1;
    want <= 1'b1;
    k = 0;
    while (grdy !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(k, P_ST + 1);
    cyc(1);
    chk({rdy, sok}, 2'b11);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 3 : 10 + $urandom % 91;
      fe();
      dt <= 7'(d);
      ch <= 3'h7;
      cl <= 3'h0;
      d = (d < 10) ? 10 : d;
      cyc(120);
      gap(1'b0, d);
      gap(1'b1, d);
    end
    fe();
    ch <= 3'h0;
    cyc(d + 20);
    fe();
    ch <= 3'h7;
    k = 0;
    while (gh[0] !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(k <= 3, 1);
    for (int i = 0; i < 16; i++) begin
      fe();
      three <= i[3];
      ch <= 3'($urandom);
      cl <= 3'($urandom);
      cyc(d + 6);
      for (int p = 0; p < 3; p++) chk({gh[p], gl[p]}, gexp(three, ch[p], cl[p]));
    end
    fe();
    three <= 1'b0;
    ch <= 3'h7;
    cl <= 3'h0;
    cyc(d + 6);
    b = $urandom % 6;
    fe();
    vds <= 6'(1 << b);
    cyc(1);
    chk({gh, gl, fn, wn, ocs}, {8'h00, 6'(1 << b)});
    fe();
    vds <= 6'h00;
    k = 1;
    while (wn !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    chk(k, P_OC + 1);
    chk({gh, gl, fn}, 7'h00);
    fclear();
    chk({fn, ocs}, 7'h40);
    fe();
    uv <= 1'b1;
    fe();
    uv <= 1'b0;
    cyc(1);
    chk({fn, uvs}, 2'b01);
    fe();
    en <= 1'b0;
    repeat (5) fe();
    en <= 1'b1;
    cyc(2);
    chk({grdy, fn, uvs}, 3'b110);
    // too long a low pulse forces the full start-up again
    fe();
    en <= 1'b0;
    cyc(2010);
    fe();
    en <= 1'b1;
    cyc(2);
    chk(grdy, 1'b0);
    cyc(P_ST + 2);
    chk(grdy, 1'b1);
    // supply loss drops readiness at once and needs a full start-up
    fe();
    sup <= 1'b0;
    cyc(2);
    chk({grdy, rdy}, 2'b00);
    fe();
    sup <= 1'b1;
    cyc(P_ST + 2);
    chk({grdy, rdy}, 2'b11);
    otw_m = 0;
    foreach (tq[i]) begin
      fe();
      temp <= 8'(tq[i]);
      cyc(2);
      if (tq[i] >= 130) otw_m = 1;
      else if (tq[i] <= 115) otw_m = 0;
      chk({overtemp_warning, wn}, {otw_m[0], !otw_m[0]});
    end
    chk({overtemp_shutdown, fn}, 2'b10);
    fclear();
    chk({overtemp_shutdown, fn, grdy}, 3'b011);
    tally_and_finish();
  end
endmodule
`default_nettype wire
